// *** ptu_pkg.sv ***
// package: register map, field layout and divider taps of the periodic tick unit
package ptu_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] PTU_OFS_CONTROL = 8'h00;
    localparam logic [7:0] PTU_OFS_STATUS = 8'h04;
    localparam logic [7:0] PTU_OFS_MASK = 8'h08;

    // ----------------------------------------------------------------
    // timebase_control field positions
    // ----------------------------------------------------------------
    localparam int PTU_BIT_PENDING = 7;
    localparam int PTU_BIT_RATE_LSB = 4;
    localparam int PTU_BIT_ACK = 3;
    localparam int PTU_BIT_IRQ_EN = 2;
    localparam int PTU_BIT_ENABLE = 1;
    localparam int PTU_RATE_W = 3;

    // ----------------------------------------------------------------
    // status / mask layout
    // ----------------------------------------------------------------
    localparam int PTU_EVT_W = 2;
    localparam int PTU_EVT_TICK = 0;
    localparam int PTU_EVT_WAKE = 1;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] PTU_RST_RATE = 3'h0;
    localparam logic [1:0] PTU_RST_EVT = 2'h0;

    // ----------------------------------------------------------------
    // divider chain
    // ----------------------------------------------------------------
    localparam int PTU_STAGES = 18;
    localparam int PTU_TAP_W = 5;
    // flag fires when the selected tap stage itself rises
    localparam logic [4:0] PTU_TAP_R0 = 5'h11;
    localparam logic [4:0] PTU_TAP_R1 = 5'h10;
    localparam logic [4:0] PTU_TAP_R2 = 5'h0f;
    localparam logic [4:0] PTU_TAP_R3 = 5'h0e;
    localparam logic [4:0] PTU_TAP_R4 = 5'h05;
    localparam logic [4:0] PTU_TAP_R5 = 5'h04;
    localparam logic [4:0] PTU_TAP_R6 = 5'h03;
    localparam logic [4:0] PTU_TAP_R7 = 5'h02;

    // ----------------------------------------------------------------
    // wishbone request carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ptu_wb_req_t;

    function automatic logic [4:0] ptu_tap(input logic [2:0] rate);
        logic [4:0] t;
        t = PTU_TAP_R0;
        case (rate)
            3'h0: t = PTU_TAP_R0;
            3'h1: t = PTU_TAP_R1;
            3'h2: t = PTU_TAP_R2;
            3'h3: t = PTU_TAP_R3;
            3'h4: t = PTU_TAP_R4;
            3'h5: t = PTU_TAP_R5;
            3'h6: t = PTU_TAP_R6;
            default: t = PTU_TAP_R7;
        endcase
        return t;
    endfunction

endpackage

// *** ptu_divider.sv ***
// module: 18-stage divider chain with selectable overflow tap
`timescale 1ns/1ns
module ptu_divider #(
    parameter int STAGES = ptu_pkg::PTU_STAGES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic clear_i,
    input wire logic step_i,
    input wire logic [2:0] rate_i,
    // results
    output logic [STAGES-1:0] count_o,
    output logic event_o
);
    import ptu_pkg::*;

    if (STAGES != PTU_STAGES) begin : g_check
        $error("ptu_divider: tap table serves exactly 18 stages");
    end

    logic [STAGES-1:0] next_count;
    logic [4:0] tap;
    logic next_event;

    assign next_count = clear_i ? '0 : (step_i ? count_o + 1'b1 : count_o);
    assign tap = ptu_tap(rate_i);
    // rising edge of the tap stage itself: half period first, full period after
    assign next_event = step_i & ~clear_i & next_count[tap] & ~count_o[tap];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
            event_o <= 1'b0;
        end else begin
            count_o <= next_count;
            event_o <= next_event;
        end
    end

endmodule

// *** ptu_top.sv ***
// module: periodic tick unit with wishbone register slave and interrupt logic
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ns

// Summary of operation
// - counter held at zero while tick_enable is clear, counts oscillator cycles when set
// - divider is an 18-stage chain with eight selectable overflow taps
// - overflow at the selected tap sets the pending flag
// - interrupt request while pending flag and tick_irq_enable are both one
// - first flag after enable comes at about half the selected period
// - later flags come at exactly the selected period
// - rate codes 0..7 divide by 262144,131072,65536,32768,64,32,16,8
// - acknowledge bit is write-only, reads zero, writing one clears pending
// - pending flag is read-only; writes to its bit are ignored
// - reset clears enable; toggling enable off then on restarts counter
// - in wait mode counting continues but the register is not accessible
// - in stop mode counting only with oscillator kept; register inaccessible
module ptu_top #(
    parameter int STAGES = ptu_pkg::PTU_STAGES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire ptu_pkg::ptu_wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // oscillator and power modes
    input wire logic oscillator_clock_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic stop_osc_keep_i,
    // interrupts
    output logic tick_irq_o,
    output logic irq_o
);
    import ptu_pkg::*;

    if (STAGES < PTU_STAGES) begin : g_check
        $error("ptu_top: fewer than 18 divider stages");
    end

    // ----------------------------------------------------------------
    // oscillator synchroniser and step detect
    // ----------------------------------------------------------------
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic osc_step;
    assign osc_step = osc_sync & ~osc_prev;

    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    logic tick_enable;
    logic tick_irq_enable;
    logic [PTU_RATE_W-1:0] tick_rate_select;
    logic tick_pending_flag;
    logic [PTU_EVT_W-1:0] evt_status;
    logic [PTU_EVT_W-1:0] evt_mask;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic bus_req;
    logic bus_blocked;
    logic bus_go;
    logic wr_go;
    logic rd_go;
    logic hit_ctl;
    logic hit_stat;
    logic hit_mask;
    logic ack_write;
    logic [7:0] ctl_read;
    logic [31:0] read_mux;

    assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
    // the cpu cannot reach the register in wait or stop; access is answered but inert
    assign bus_blocked = wait_mode_i | stop_mode_i;
    assign bus_go = bus_req & ~bus_blocked;
    assign wr_go = bus_go & wb_req_i.we & wb_req_i.sel[0];
    assign rd_go = bus_go & ~wb_req_i.we;
    assign hit_ctl = wb_req_i.adr == PTU_OFS_CONTROL;
    assign hit_stat = wb_req_i.adr == PTU_OFS_STATUS;
    assign hit_mask = wb_req_i.adr == PTU_OFS_MASK;
    assign ack_write = wr_go & hit_ctl & wb_req_i.dat[PTU_BIT_ACK];

    // acknowledge bit always reads as zero, bit 0 reserved
    assign ctl_read = {tick_pending_flag, tick_rate_select, 1'b0, tick_irq_enable,
                       tick_enable, 1'b0};
    assign read_mux = hit_ctl ? {24'h000000, ctl_read} :
                      hit_stat ? {{(32-PTU_EVT_W){1'b0}}, evt_status} :
                      hit_mask ? {{(32-PTU_EVT_W){1'b0}}, evt_mask} : 32'h00000000;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    logic div_run;
    logic div_clear;
    logic [STAGES-1:0] div_count;
    logic div_event;

    // with stop and no kept oscillator the chain freezes rather than clears
    assign div_run = osc_step & (~stop_mode_i | stop_osc_keep_i);
    assign div_clear = ~tick_enable;

    // rate is sampled live, so a change while enabled may skip or add a tick
    ptu_divider #(
        .STAGES(STAGES)
    ) u_divider (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(div_clear),
        .step_i(div_run),
        .rate_i(tick_rate_select),
        .count_o(div_count),
        .event_o(div_event)
    );

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    logic next_pending;
    logic [PTU_EVT_W-1:0] evt_in;
    logic [PTU_EVT_W-1:0] evt_clear;
    logic [PTU_EVT_W-1:0] next_status;
    logic next_irq;
    logic next_tick_irq;

    // a new overflow wins over an acknowledge in the same cycle
    assign next_pending = div_event | (tick_pending_flag & ~ack_write);
    assign evt_in = {div_event & stop_mode_i, div_event};
    assign evt_clear = (wr_go & hit_stat) ? wb_req_i.dat[PTU_EVT_W-1:0] : PTU_RST_EVT;
    assign next_status = evt_in | (evt_status & ~evt_clear);
    assign next_tick_irq = next_pending & tick_irq_enable;
    assign next_irq = |(next_status & evt_mask);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= oscillator_clock_i;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_enable <= 1'b0;
            tick_irq_enable <= 1'b0;
            tick_rate_select <= PTU_RST_RATE;
            tick_pending_flag <= 1'b0;
        end else begin
            tick_pending_flag <= next_pending;
            if (wr_go && hit_ctl) begin
                tick_enable <= wb_req_i.dat[PTU_BIT_ENABLE];
                tick_irq_enable <= wb_req_i.dat[PTU_BIT_IRQ_EN];
                tick_rate_select <= wb_req_i.dat[PTU_BIT_RATE_LSB +: PTU_RATE_W];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_status <= PTU_RST_EVT;
            evt_mask <= PTU_RST_EVT;
            tick_irq_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            evt_status <= next_status;
            tick_irq_o <= next_tick_irq;
            irq_o <= next_irq;
            if (wr_go && hit_mask) begin
                evt_mask <= wb_req_i.dat[PTU_EVT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd_go ? read_mux : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic [4:0] chk_tap;
    logic [STAGES-1:0] chk_low;
    assign chk_tap = ptu_tap(tick_rate_select);
    assign chk_low = div_count & ((({{(STAGES-1){1'b0}}, 1'b1}) << chk_tap) - 1'b1);

    sequence s_ctl_write_ack;
        wr_go && hit_ctl && wb_req_i.dat[PTU_BIT_ACK];
    endsequence

    sequence s_no_event;
        !div_event;
    endsequence

    a_counter_held: assert property (@(posedge clk_i) disable iff (rst_i)
        !tick_enable |=> div_count == '0)
        else $error("counter not held at zero while disabled");

    a_event_tap_point: assert property (@(posedge clk_i) disable iff (rst_i)
        div_event && $stable(tick_rate_select) |-> div_count[chk_tap] && chk_low == '0)
        else $error("tick event away from the selected tap point");

    a_event_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        div_event |=> tick_pending_flag)
        else $error("overflow did not set pending flag");

    a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_pending_flag && tick_irq_enable |=> tick_irq_o || $past(ack_write))
        else $error("request missing while pending and enabled");

    a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !tick_irq_enable ##1 !tick_irq_enable |-> !tick_irq_o)
        else $error("request raised with interrupt enable clear");

    a_ack_clears_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ctl_write_ack and s_no_event |=> !tick_pending_flag)
        else $error("acknowledge did not clear pending flag");

    a_ack_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> !wb_dat_o[PTU_BIT_ACK])
        else $error("acknowledge bit read back as one");

    a_flag_set_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(tick_pending_flag) |-> $past(div_event))
        else $error("pending flag set without an overflow");

    a_blocked_access: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && bus_blocked |=> wb_ack_o && wb_dat_o == 32'h00000000 && $stable(tick_enable))
        else $error("register reached during wait or stop");

    a_stop_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_mode_i && !stop_osc_keep_i && tick_enable ##1 tick_enable |-> $stable(div_count))
        else $error("divider moved in stop without kept oscillator");

    a_reset_state: assert property (@(posedge clk_i)
        rst_i |=> !tick_enable && !tick_pending_flag && !tick_irq_enable && tick_rate_select == PTU_RST_RATE)
        else $error("control state not cleared by reset");

    a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone answer not one cycle after request");

    // overflow, then flag kept for a cycle: the request must follow
    sequence s_event_armed;
        div_event && tick_irq_enable;
    endsequence

    sequence s_flag_kept;
        tick_irq_enable && !ack_write;
    endsequence

    a_event_to_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        s_event_armed ##1 s_flag_kept |=> tick_irq_o)
        else $error("overflow with interrupt enabled raised no request");

    a_event_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        div_event |-> $past(tick_enable))
        else $error("tick event while the timebase was disabled");

    a_divider_step: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_enable && div_run |=> div_count == $past(div_count) + 1'b1)
        else $error("divider did not advance on an oscillator step");

    a_divider_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_enable && !div_run |=> $stable(div_count))
        else $error("divider moved without an oscillator step");

    a_wait_runs: assert property (@(posedge clk_i) disable iff (rst_i)
        wait_mode_i && !stop_mode_i && tick_enable && osc_step |=> div_count != $past(div_count))
        else $error("divider stalled in wait mode");

    a_stop_kept_runs: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_mode_i && stop_osc_keep_i && tick_enable && osc_step |=> div_count != $past(div_count))
        else $error("divider stalled in stop with oscillator kept");

    a_wake_status: assert property (@(posedge clk_i) disable iff (rst_i)
        div_event && stop_mode_i |=> evt_status[PTU_EVT_WAKE] && evt_status[PTU_EVT_TICK])
        else $error("tick in stop did not set the wake status");

    a_flag_write_inert: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && hit_ctl && !tick_pending_flag && !div_event |=> !tick_pending_flag)
        else $error("register write set the pending flag");

    a_irq_from_status: assert property (@(posedge clk_i) disable iff (rst_i)
        !(|(evt_status & evt_mask)) && !div_event |=> !irq_o)
        else $error("status interrupt raised with nothing unmasked pending");

endmodule

// *** ptu_top_tb.sv ***
// testbench: self-checking bench of the periodic tick unit
`timescale 1ns/1ns
module ptu_top_tb;
    import ptu_pkg::*;

    // ----------------------------------------------------------------
    // clock, design and shared helpers
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ptu_wb_req_t wb_req = '0;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic tick_irq;
    logic irq;
    logic osc = 1'b0;
    logic wait_m = 1'b0;
    logic stop_m = 1'b0;
    logic keep = 1'b0;
    logic [31:0] rd;
    logic [31:0] pend_bit = 32'h1 << PTU_BIT_PENDING;
    int num_errors = 0;
    int comparisons = 0;
    int n;
    int t;
    int k;
    logic ie;

    always #10 clk_i = ~clk_i;

    ptu_top #(.STAGES(18)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack), .oscillator_clock_i(osc), .wait_mode_i(wait_m), .stop_mode_i(stop_m),
        .stop_osc_keep_i(keep), .tick_irq_o(tick_irq), .irq_o(irq));

    // overflow stage: divide by 2^(tap+1), first flag after 2^tap steps
    function automatic int tap_of(input logic [2:0] r);
        return r[2] ? 9 - int'(r) : 17 - int'(r);
    endfunction

    function automatic logic [31:0] ctl(input logic [2:0] r, input logic ie_v, input logic en, input logic ack);
        return (32'(r) << PTU_BIT_RATE_LSB) | (32'(ack) << PTU_BIT_ACK) | (32'(ie_v) << PTU_BIT_IRQ_EN)
            | (32'(en) << PTU_BIT_ENABLE);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // request held until ack is seen at a rising edge; read data is taken at that edge
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] r);
        int w;
        w = 0;
        @(posedge clk_i);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && w < 50) begin
            @(posedge clk_i);
            w++;
        end
        if (w >= 50) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        end
        r = wb_dat;
        wb_req <= '0;
    endtask

    // each step is a full oscillator period, slow enough for the two-stage synchroniser
    task automatic steps(input int cnt);
        repeat (cnt) begin
            @(posedge clk_i);
            osc <= 1'b1;
            repeat (5) @(posedge clk_i);
            osc <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask

    task automatic count_irq(output int cnt);
        cnt = 0;
        @(negedge clk_i);
        while (tick_irq !== 1'b1 && cnt < 600) begin
            steps(1);
            cnt++;
            @(negedge clk_i);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(39));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_cycle(1'b0, PTU_OFS_CONTROL, 32'h0, rd);
        check(rd, 32'h0);
        wb_cycle(1'b0, PTU_OFS_STATUS, 32'h0, rd);
        check(rd, 32'h0);
        wb_cycle(1'b0, PTU_OFS_MASK, 32'h0, rd);
        check(rd, 32'h0);
        wb_cycle(1'b1, 8'h0c, 32'hff, rd);
        wb_cycle(1'b0, 8'h0c, 32'h0, rd);
        check(rd, 32'h0);
        $display("test reset values done");
        for (int r = 0; r < 8; r++) begin
            ie = 1'($urandom);
            wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'(r), ie, 1'b0, 1'b1) | pend_bit, rd);
            wb_cycle(1'b0, PTU_OFS_CONTROL, 32'h0, rd);
            check(rd, ctl(3'(r), ie, 1'b0, 1'b0));
        end
        $display("test register fields done");
        for (int r = 4; r < 8; r++) begin
            t = tap_of(3'(r));
            k = int'($urandom_range(2 ** t - 1, 1));
            wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'(r), 1'b1, 1'b1, 1'b0), rd);
            steps(k);
            wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'(r), 1'b1, 1'b0, 1'b0), rd);
            steps(2);
            wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'(r), 1'b1, 1'b1, 1'b0), rd);
            wb_cycle(1'b1, PTU_OFS_MASK, 32'(r % 2), rd);
            count_irq(n);
            check(32'(n), 32'(2 ** t));
            check(32'(irq), 32'(r % 2));
            wb_cycle(1'b0, PTU_OFS_STATUS, 32'h0, rd);
            check(rd, 32'h1);
            wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'(r), 1'b1, 1'b1, 1'b1), rd);
            repeat (2) @(negedge clk_i);
            check(32'(tick_irq), 32'h0);
            count_irq(n);
            check(32'(n), 32'(2 ** (t + 1)));
            wb_cycle(1'b1, PTU_OFS_STATUS, 32'h3, rd);
            wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'(r), 1'b1, 1'b1, 1'b1), rd);
            wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'(r), 1'b1, 1'b0, 1'b0), rd);
            repeat (2) @(negedge clk_i);
            check(32'(irq), 32'h0);
            $display("test rate %0d done", r);
        end
        wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'h7, 1'b1, 1'b1, 1'b0), rd);
        @(posedge clk_i);
        wait_m <= 1'b1;
        wb_cycle(1'b0, PTU_OFS_CONTROL, 32'h0, rd);
        check(rd, 32'h0);
        wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'h7, 1'b1, 1'b0, 1'b0), rd);
        count_irq(n);
        check(32'(n), 32'h4);
        @(posedge clk_i);
        wait_m <= 1'b0;
        wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'h7, 1'b1, 1'b1, 1'b1), rd);
        $display("test wait mode done");
        @(posedge clk_i);
        stop_m <= 1'b1;
        steps(8);
        @(negedge clk_i);
        check(32'(tick_irq), 32'h0);
        @(posedge clk_i);
        keep <= 1'b1;
        count_irq(n);
        check(32'(n), 32'h8);
        wb_cycle(1'b0, PTU_OFS_CONTROL, 32'h0, rd);
        check(rd, 32'h0);
        stop_m <= 1'b0;
        keep <= 1'b0;
        wb_cycle(1'b0, PTU_OFS_STATUS, 32'h0, rd);
        check(rd, 32'h3);
        $display("test stop mode done");
        wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'h7, 1'b0, 1'b1, 1'b1), rd);
        steps(8);
        @(negedge clk_i);
        check(32'(tick_irq), 32'h0);
        wb_cycle(1'b0, PTU_OFS_CONTROL, 32'h0, rd);
        check(rd, ctl(3'h7, 1'b0, 1'b1, 1'b0) | pend_bit);
        wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'h7, 1'b0, 1'b1, 1'b0), rd);
        wb_cycle(1'b0, PTU_OFS_CONTROL, 32'h0, rd);
        check(rd, ctl(3'h7, 1'b0, 1'b1, 1'b0) | pend_bit);
        wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'h7, 1'b0, 1'b1, 1'b1), rd);
        wb_cycle(1'b0, PTU_OFS_CONTROL, 32'h0, rd);
        check(rd, ctl(3'h7, 1'b0, 1'b1, 1'b0));
        $display("test masked request done");
        wb_cycle(1'b1, PTU_OFS_CONTROL, ctl(3'h7, 1'b1, 1'b1, 1'b0), rd);
        steps(8);
        @(negedge clk_i);
        check(32'(tick_irq), 32'h1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_cycle(1'b0, PTU_OFS_CONTROL, 32'h0, rd);
        check(rd, 32'h0);
        check(32'(tick_irq), 32'h0);
        check(32'(irq), 32'h0);
        $display("test second reset done");
        tally_and_finish();
    end

    // whole run is a few thousand cycles; this bound only catches a hang
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        $display("watchdog expired at %0t", $time);
        tally_and_finish();
    end
endmodule
